// ---- logic/ivp_arbiter.sv ----
// Interrupt vector and priority arbiter for the processor core
// Summary of operation
// (R1) Reset, stack error, trace and software interrupt vector to 0000, 0002, 0004 and 0006 at level 3.
// (R2) The non-maskable interrupt vectors to 001e and the illegal-instruction trap to 003e, both at level 3.
// (R3) External request A vectors to 0008 and B to 000a, each at a programmable level 0 to 2.
// (R4) With the transmit select low, left, right and exception transmit use 0010, 0012 and 0014.
// (R5) With the transmit select high, those transmit vectors move to 0040, 0042 and 0044.
// (R6) With the receive select low, left, right and exception receive use 0016, 0018 and 001a.
// (R7) With the receive select high, those receive vectors move to 0046, 0048 and 004a.
// (R8) Host transmit data, underrun and receive-not-empty vector to 0020, 0022 and 0024.
// (R9) Host receive full, overrun and bus error vector to 0028, 002a and 002c.
// (R10) Memory write data, read data, pointer 0 wrap and pointer 1 wrap use 0030, 0032, 0034, 0036.
// (R11) Request lines and all audio, host and memory sources are maskable at level 0, 1 or 2.
// (R12) Level-3 order is reset, illegal, non-maskable, stack error, trace, software interrupt.
// (R13) Maskable order starts request A, B, rx exc, tx exc, left rx, left tx, right rx, right tx.
// (R14) Then host bus error, overrun, underrun, rx full, tx data, rx not empty, wrap 0, wrap 1, read, write.
// (R15) The highest pending enabled level wins first, the fixed in-level order breaks ties.
// (R16) Reserved vector slots are never produced.
`timescale 1ns/100ps
`default_nettype none
`include "ivp_defs.svh"

module ivp_arbiter (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Requests from peripherals and core
    input wire ivp_pkg::ivp_fixed_req_s fixed_req_i,
    input wire ivp_pkg::ivp_mask_req_s mask_req_i,
    // Configuration from the core mask logic
    input wire ivp_pkg::ivp_levels_s levels_i,
    input wire logic [`IVP_LVL_W-1:0] core_mask_level_i,
    input wire logic audio_tx_vector_select_i,
    input wire logic audio_rx_vector_select_i,
    // Chosen request to the core
    output ivp_pkg::ivp_grant_s grant_o
);
    import ivp_pkg::*;

    localparam int NSRC = `IVP_NUM_MASKABLE;

    // Per-source level enable: 2'h3 on a maskable source means disabled
    ivp_lvl_t src_lvl [NSRC];
    logic [NSRC-1:0] src_req;
    ivp_vec_t src_vec [NSRC];
    logic [NSRC-1:0] src_en;
    logic [`IVP_NUM_FIXED-1:0] fix_req;
    ivp_grant_s grant_d;
    ivp_grant_s grant_q;

    always_comb begin
        src_req[`IVP_SRC_REQ_A] = mask_req_i.ext_request_a;
        src_req[`IVP_SRC_REQ_B] = mask_req_i.ext_request_b;
        src_req[`IVP_SRC_RX_EXC] = mask_req_i.audio_rx_exc;
        src_req[`IVP_SRC_TX_EXC] = mask_req_i.audio_tx_exc;
        src_req[`IVP_SRC_RX_LEFT] = mask_req_i.audio_rx_left;
        src_req[`IVP_SRC_TX_LEFT] = mask_req_i.audio_tx_left;
        src_req[`IVP_SRC_RX_RIGHT] = mask_req_i.audio_rx_right;
        src_req[`IVP_SRC_TX_RIGHT] = mask_req_i.audio_tx_right;
        src_req[`IVP_SRC_HOST_BUSERR] = mask_req_i.host_bus_error;
        src_req[`IVP_SRC_HOST_OVER] = mask_req_i.host_rx_overrun;
        src_req[`IVP_SRC_HOST_UNDER] = mask_req_i.host_tx_underrun;
        src_req[`IVP_SRC_HOST_FULL] = mask_req_i.host_rx_full;
        src_req[`IVP_SRC_HOST_TX] = mask_req_i.host_tx_data;
        src_req[`IVP_SRC_HOST_NEMPTY] = mask_req_i.host_rx_not_empty;
        src_req[`IVP_SRC_MEM_WRAP0] = mask_req_i.mem_wrap_0;
        src_req[`IVP_SRC_MEM_WRAP1] = mask_req_i.mem_wrap_1;
        src_req[`IVP_SRC_MEM_RD] = mask_req_i.mem_read_data;
        src_req[`IVP_SRC_MEM_WR] = mask_req_i.mem_write_data;
    end

    always_comb begin
        src_lvl[`IVP_SRC_REQ_A] = levels_i.ext_request_a; // R3
        src_lvl[`IVP_SRC_REQ_B] = levels_i.ext_request_b; // R3
        for (int i = `IVP_SRC_RX_EXC; i <= `IVP_SRC_TX_RIGHT; i++) begin
            src_lvl[i] = levels_i.serial_audio_port; // R11
        end
        for (int i = `IVP_SRC_HOST_BUSERR; i <= `IVP_SRC_HOST_NEMPTY; i++) begin
            src_lvl[i] = levels_i.serial_host_port; // R11
        end
        for (int i = `IVP_SRC_MEM_WRAP0; i <= `IVP_SRC_MEM_WR; i++) begin
            src_lvl[i] = levels_i.external_memory_port; // R11
        end
    end

    // Vector table; the alternate audio table follows the select bits
    always_comb begin
        src_vec[`IVP_SRC_REQ_A] = `IVP_VEC_REQ_A; // R3
        src_vec[`IVP_SRC_REQ_B] = `IVP_VEC_REQ_B; // R3
        if (audio_tx_vector_select_i) begin
            src_vec[`IVP_SRC_TX_LEFT] = `IVP_VEC_TX_LEFT_ALT; // R5
            src_vec[`IVP_SRC_TX_RIGHT] = `IVP_VEC_TX_RIGHT_ALT; // R5
            src_vec[`IVP_SRC_TX_EXC] = `IVP_VEC_TX_EXC_ALT; // R5
        end else begin
            src_vec[`IVP_SRC_TX_LEFT] = `IVP_VEC_TX_LEFT; // R4
            src_vec[`IVP_SRC_TX_RIGHT] = `IVP_VEC_TX_RIGHT; // R4
            src_vec[`IVP_SRC_TX_EXC] = `IVP_VEC_TX_EXC; // R4
        end
        if (audio_rx_vector_select_i) begin
            src_vec[`IVP_SRC_RX_LEFT] = `IVP_VEC_RX_LEFT_ALT; // R7
            src_vec[`IVP_SRC_RX_RIGHT] = `IVP_VEC_RX_RIGHT_ALT; // R7
            src_vec[`IVP_SRC_RX_EXC] = `IVP_VEC_RX_EXC_ALT; // R7
        end else begin
            src_vec[`IVP_SRC_RX_LEFT] = `IVP_VEC_RX_LEFT; // R6
            src_vec[`IVP_SRC_RX_RIGHT] = `IVP_VEC_RX_RIGHT; // R6
            src_vec[`IVP_SRC_RX_EXC] = `IVP_VEC_RX_EXC; // R6
        end
        src_vec[`IVP_SRC_HOST_TX] = `IVP_VEC_HOST_TX; // R8
        src_vec[`IVP_SRC_HOST_UNDER] = `IVP_VEC_HOST_UNDER; // R8
        src_vec[`IVP_SRC_HOST_NEMPTY] = `IVP_VEC_HOST_NEMPTY; // R8
        src_vec[`IVP_SRC_HOST_FULL] = `IVP_VEC_HOST_FULL; // R9
        src_vec[`IVP_SRC_HOST_OVER] = `IVP_VEC_HOST_OVER; // R9
        src_vec[`IVP_SRC_HOST_BUSERR] = `IVP_VEC_HOST_BUSERR; // R9
        src_vec[`IVP_SRC_MEM_WR] = `IVP_VEC_MEM_WR; // R10
        src_vec[`IVP_SRC_MEM_RD] = `IVP_VEC_MEM_RD; // R10
        src_vec[`IVP_SRC_MEM_WRAP0] = `IVP_VEC_MEM_WRAP0; // R10
        src_vec[`IVP_SRC_MEM_WRAP1] = `IVP_VEC_MEM_WRAP1; // R10
    end

    // A source counts only if enabled and its level is at or above the core mask
    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            src_en[i] = src_req[i] && (src_lvl[i] != `IVP_LVL_TOP)
                && (src_lvl[i] >= core_mask_level_i); // R11
        end
    end

    always_comb begin
        fix_req[`IVP_FIX_RESET] = fixed_req_i.hw_reset;
        fix_req[`IVP_FIX_ILLEGAL] = fixed_req_i.illegal;
        fix_req[`IVP_FIX_NMI] = fixed_req_i.nmi;
        fix_req[`IVP_FIX_STACK] = fixed_req_i.stack_error;
        fix_req[`IVP_FIX_TRACE] = fixed_req_i.trace;
        fix_req[`IVP_FIX_SWINT] = fixed_req_i.software_interrupt;
    end

    function automatic ivp_vec_t fixed_vec(input int idx);
        case (idx)
            `IVP_FIX_RESET: fixed_vec = `IVP_VEC_RESET; // R1
            `IVP_FIX_ILLEGAL: fixed_vec = `IVP_VEC_ILLEGAL; // R2
            `IVP_FIX_NMI: fixed_vec = `IVP_VEC_NMI; // R2
            `IVP_FIX_STACK: fixed_vec = `IVP_VEC_STACK; // R1
            `IVP_FIX_TRACE: fixed_vec = `IVP_VEC_TRACE; // R1
            default: fixed_vec = `IVP_VEC_SWINT; // R1
        endcase
    endfunction

    // Level first, then index order; lower index wins a tie by scanning downward
    always_comb begin
        grant_d = '0;
        for (int i = `IVP_NUM_FIXED - 1; i >= 0; i--) begin
            if (fix_req[i]) begin
                grant_d.valid = 1'b1; // R12
                grant_d.priority_level = `IVP_LVL_TOP;
                grant_d.vector = fixed_vec(i);
            end
        end
        if (!grant_d.valid) begin
            for (int i = NSRC - 1; i >= 0; i--) begin
                if (src_en[i] && (!grant_d.valid
                        || src_lvl[i] >= grant_d.priority_level)) begin
                    grant_d.valid = 1'b1; // R15 R13 R14
                    grant_d.priority_level = src_lvl[i];
                    grant_d.vector = src_vec[i];
                end
            end
        end
    end

    // Only table entries reach the output, so reserved slots cannot appear
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            grant_q <= '0;
        end else begin
            grant_q <= grant_d; // R16
        end
    end

    assign grant_o = grant_q;
endmodule

`default_nettype wire

// ---- logic/ivp_defs.svh ----
// Vector addresses, source indices and level encodings for the interrupt vector/priority block
`ifndef IVP_DEFS_SVH
`define IVP_DEFS_SVH

`define IVP_VEC_W 16
`define IVP_LVL_W 2
`define IVP_LVL_TOP 2'h3
`define IVP_NUM_MASKABLE 18
`define IVP_NUM_FIXED 6

// Fixed-level vectors
`define IVP_VEC_RESET 16'h0000
`define IVP_VEC_STACK 16'h0002
`define IVP_VEC_TRACE 16'h0004
`define IVP_VEC_SWINT 16'h0006
`define IVP_VEC_NMI 16'h001e
`define IVP_VEC_ILLEGAL 16'h003e

// Maskable vectors
`define IVP_VEC_REQ_A 16'h0008
`define IVP_VEC_REQ_B 16'h000a
`define IVP_VEC_TX_LEFT 16'h0010
`define IVP_VEC_TX_RIGHT 16'h0012
`define IVP_VEC_TX_EXC 16'h0014
`define IVP_VEC_RX_LEFT 16'h0016
`define IVP_VEC_RX_RIGHT 16'h0018
`define IVP_VEC_RX_EXC 16'h001a
`define IVP_VEC_TX_LEFT_ALT 16'h0040
`define IVP_VEC_TX_RIGHT_ALT 16'h0042
`define IVP_VEC_TX_EXC_ALT 16'h0044
`define IVP_VEC_RX_LEFT_ALT 16'h0046
`define IVP_VEC_RX_RIGHT_ALT 16'h0048
`define IVP_VEC_RX_EXC_ALT 16'h004a
`define IVP_VEC_HOST_TX 16'h0020
`define IVP_VEC_HOST_UNDER 16'h0022
`define IVP_VEC_HOST_NEMPTY 16'h0024
`define IVP_VEC_HOST_FULL 16'h0028
`define IVP_VEC_HOST_OVER 16'h002a
`define IVP_VEC_HOST_BUSERR 16'h002c
`define IVP_VEC_MEM_WR 16'h0030
`define IVP_VEC_MEM_RD 16'h0032
`define IVP_VEC_MEM_WRAP0 16'h0034
`define IVP_VEC_MEM_WRAP1 16'h0036

// Maskable source indices, in descending in-level priority order
`define IVP_SRC_REQ_A 0
`define IVP_SRC_REQ_B 1
`define IVP_SRC_RX_EXC 2
`define IVP_SRC_TX_EXC 3
`define IVP_SRC_RX_LEFT 4
`define IVP_SRC_TX_LEFT 5
`define IVP_SRC_RX_RIGHT 6
`define IVP_SRC_TX_RIGHT 7
`define IVP_SRC_HOST_BUSERR 8
`define IVP_SRC_HOST_OVER 9
`define IVP_SRC_HOST_UNDER 10
`define IVP_SRC_HOST_FULL 11
`define IVP_SRC_HOST_TX 12
`define IVP_SRC_HOST_NEMPTY 13
`define IVP_SRC_MEM_WRAP0 14
`define IVP_SRC_MEM_WRAP1 15
`define IVP_SRC_MEM_RD 16
`define IVP_SRC_MEM_WR 17

// Fixed-level source indices, in descending priority order
`define IVP_FIX_RESET 0
`define IVP_FIX_ILLEGAL 1
`define IVP_FIX_NMI 2
`define IVP_FIX_STACK 3
`define IVP_FIX_TRACE 4
`define IVP_FIX_SWINT 5

`endif

// ---- logic/ivp_pkg.sv ----
// Types shared by the interrupt vector/priority block
`default_nettype none
`include "ivp_defs.svh"

package ivp_pkg;
    typedef logic [`IVP_VEC_W-1:0] ivp_vec_t;
    typedef logic [`IVP_LVL_W-1:0] ivp_lvl_t;

    // Level-3 requests, one bit per source
    typedef struct packed {
        logic software_interrupt;
        logic trace;
        logic stack_error;
        logic nmi;
        logic illegal;
        logic hw_reset;
    } ivp_fixed_req_s;

    // Maskable requests grouped by peripheral
    typedef struct packed {
        logic ext_request_a;
        logic ext_request_b;
        logic audio_tx_left;
        logic audio_tx_right;
        logic audio_tx_exc;
        logic audio_rx_left;
        logic audio_rx_right;
        logic audio_rx_exc;
        logic host_tx_data;
        logic host_tx_underrun;
        logic host_rx_not_empty;
        logic host_rx_full;
        logic host_rx_overrun;
        logic host_bus_error;
        logic mem_write_data;
        logic mem_read_data;
        logic mem_wrap_0;
        logic mem_wrap_1;
    } ivp_mask_req_s;

    // Priority level per request line or peripheral port, 0..2 when enabled
    typedef struct packed {
        ivp_lvl_t ext_request_a;
        ivp_lvl_t ext_request_b;
        ivp_lvl_t serial_audio_port;
        ivp_lvl_t serial_host_port;
        ivp_lvl_t external_memory_port;
    } ivp_levels_s;

    typedef struct packed {
        logic valid;
        ivp_lvl_t priority_level;
        ivp_vec_t vector;
    } ivp_grant_s;
endpackage

`default_nettype wire

// ---- testbench/ivp_arbiter_assertions.sv ----
// Property checker for the interrupt vector and priority arbiter
`timescale 1ns/100ps
`default_nettype none
module ivp_arbiter_assertions (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Observed arbiter ports
    input wire ivp_pkg::ivp_fixed_req_s fixed_req_i,
    input wire ivp_pkg::ivp_mask_req_s mask_req_i,
    input wire ivp_pkg::ivp_levels_s levels_i,
    input wire logic [1:0] core_mask_level_i,
    input wire logic audio_tx_vector_select_i,
    input wire logic audio_rx_vector_select_i,
    input wire ivp_pkg::ivp_grant_s grant_o
);
    import ivp_pkg::*;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    reset_vec_a: assert property ($past(reset_n_i && fixed_req_i.hw_reset) |->
        grant_o == 19'h70000) else $error("reset request vector wrong");
    illegal_vec_a: assert property ($past(reset_n_i && fixed_req_i[1:0] == 2'h2) |->
        grant_o == 19'h7003e) else $error("illegal instruction vector wrong");
    nmi_vec_a: assert property ($past(reset_n_i && fixed_req_i[2:0] == 3'h4) |->
        grant_o == 19'h7001e) else $error("non-maskable vector wrong");
    fixed_wins_a: assert property ($past(reset_n_i && |fixed_req_i) |->
        grant_o.valid && grant_o.priority_level == 2'h3) else $error("fixed request lost");
    no_reserved_a: assert property (grant_o.valid |-> !grant_o.vector[0] &&
        grant_o.vector < 16'h004c && !(grant_o.vector inside {16'h000c, 16'h000e,
        16'h001c, 16'h0026, 16'h002e, [16'h0038:16'h003c]})) else $error("reserved vector");
    tx_table_a: assert property ($past(reset_n_i && fixed_req_i == 0 &&
        mask_req_i == 18'h08000 && levels_i.serial_audio_port != 2'h3 &&
        levels_i.serial_audio_port >= core_mask_level_i) |-> grant_o.vector ==
        ($past(audio_tx_vector_select_i) ? 16'h0040 : 16'h0010)) else $error("tx vector wrong");
    rx_table_a: assert property ($past(reset_n_i && fixed_req_i == 0 &&
        mask_req_i == 18'h01000 && levels_i.serial_audio_port != 2'h3 &&
        levels_i.serial_audio_port >= core_mask_level_i) |-> grant_o.vector ==
        ($past(audio_rx_vector_select_i) ? 16'h0046 : 16'h0016)) else $error("rx vector wrong");
    masked_out_a: assert property ($past(reset_n_i && fixed_req_i == 0 &&
        mask_req_i == 18'h10000 && levels_i.ext_request_b < core_mask_level_i) |->
        !grant_o.valid) else $error("masked request granted");
endmodule
bind ivp_arbiter ivp_arbiter_assertions chk (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .fixed_req_i(fixed_req_i), .mask_req_i(mask_req_i), .levels_i(levels_i),
    .core_mask_level_i(core_mask_level_i), .audio_tx_vector_select_i(audio_tx_vector_select_i),
    .audio_rx_vector_select_i(audio_rx_vector_select_i), .grant_o(grant_o));
`default_nettype wire

// ---- testbench/ivp_core_model.sv ----
// Core-side model: raises its mask to each granted level while servicing it
`timescale 1ns/100ps
`default_nettype none
module ivp_core_model (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Bench control and arbiter result
    input wire logic follow_i,
    input wire logic [1:0] forced_level_i,
    input wire ivp_pkg::ivp_grant_s grant_i,
    // Mask to the arbiter
    output logic [1:0] mask_level_o
);
    import ivp_pkg::*;
    logic [1:0] held_q;
    always_ff @(negedge mclk_i) begin
        held_q <= (reset_n_i && grant_i.valid) ? grant_i.priority_level : forced_level_i;
    end
    assign mask_level_o = follow_i ? held_q : forced_level_i;
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the interrupt vector and priority arbiter
`timescale 1ns/100ps
`default_nettype none
module tb;
    import ivp_pkg::*;
    // Maskable sources from lowest index = highest priority
    localparam int BIT_OF [18] = '{17, 16, 10, 13, 12, 15, 11, 14, 4, 5, 8, 6, 9, 7, 1, 0, 2, 3};
    localparam int GRP_OF [18] = '{4, 3, 2, 2, 2, 2, 2, 2, 1, 1, 1, 1, 1, 1, 0, 0, 0, 0};
    localparam int ALT_OF [18] = '{0, 0, 1, 2, 1, 2, 1, 2, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
    localparam logic [7:0] VEC_OF [18] = '{8'h08, 8'h0a, 8'h1a, 8'h14, 8'h16, 8'h10, 8'h18,
        8'h12, 8'h2c, 8'h2a, 8'h22, 8'h28, 8'h20, 8'h24, 8'h34, 8'h36, 8'h32, 8'h30};
    localparam logic [7:0] FIX_VEC [6] = '{8'h00, 8'h3e, 8'h1e, 8'h02, 8'h04, 8'h06};
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic follow = 1'b0;
    logic tx_sel = 1'b0;
    logic rx_sel = 1'b0;
    ivp_lvl_t forced = '0;
    ivp_lvl_t mask_lvl;
    ivp_fixed_req_s fixed = '0;
    ivp_mask_req_s mreq = '0;
    ivp_levels_s lvls = '0;
    ivp_grant_s grant;
    ivp_grant_s exp_q [$];
    logic [31:0] seed = 32'hcd95e414;
    int n_errors = 0;
    int compares = 0;
    int i;
    int k;
    always #5 mclk_i = ~mclk_i;
    ivp_arbiter dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .fixed_req_i(fixed),
        .mask_req_i(mreq), .levels_i(lvls), .core_mask_level_i(mask_lvl),
        .audio_tx_vector_select_i(tx_sel), .audio_rx_vector_select_i(rx_sel), .grant_o(grant));
    ivp_core_model core (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .follow_i(follow),
        .forced_level_i(forced), .grant_i(grant), .mask_level_o(mask_lvl));
    function automatic logic [31:0] next_rand();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    function automatic ivp_grant_s expect_g();
        ivp_grant_s g;
        ivp_lvl_t l;
        logic [7:0] v;
        g = '0;
        for (int p = 17; p >= 0; p--) begin
            l = lvls[2 * GRP_OF[p] +: 2];
            v = VEC_OF[p];
            if ((ALT_OF[p] == 1 && rx_sel) || (ALT_OF[p] == 2 && tx_sel)) v = v + 8'h30;
            if (mreq[BIT_OF[p]] && l != 2'h3 && l >= mask_lvl && l >= g.priority_level) begin
                g = {1'b1, l, 8'h00, v};
            end
        end
        for (int p = 5; p >= 0; p--) begin
            if (fixed[p]) g = {1'b1, 2'h3, 8'h00, FIX_VEC[p]};
        end
        return g;
    endfunction
    task automatic drive(input logic rst_n, input logic [5:0] f, input logic [17:0] m,
            input logic [9:0] lv, input ivp_lvl_t ml, input logic [1:0] sel);
        @(negedge mclk_i);
        reset_n_i = rst_n;
        fixed = f;
        mreq = m;
        lvls = lv;
        forced = ml;
        {rx_sel, tx_sel} = sel;
        #1;
        exp_q.push_back(reset_n_i ? expect_g() : ivp_grant_s'('0));
    endtask
    task automatic drive_rnd(input logic rst_n);
        logic [31:0] a;
        logic [31:0] b;
        a = next_rand();
        b = next_rand();
        drive(rst_n, (a[2:0] == 3'h0) ? a[8:3] : 6'h00, b[17:0], a[18:9],
            follow ? 2'h0 : a[20:19], a[22:21]);
    endtask
    task automatic check(input ivp_grant_s seen, input ivp_grant_s exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch grant_o expected %h seen %h", exp, seen);
        end
    endtask
    task automatic close_out();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge mclk_i) begin
        #1;
        if (exp_q.size() > 0) begin
            if (exp_q[0].priority_level == 2'h3) check(grant, exp_q.pop_front());
            else check(grant, exp_q.pop_front());
        end
    end
    initial begin
        #200000;
        n_errors++;
        close_out();
    end
    initial begin
        repeat (8) drive(1'b0, '0, '0, '0, 2'h0, 2'h0);
        drive(1'b1, '0, '0, '0, 2'h0, 2'h0);
        // Level-3 ranking with every lower request also pending
        for (i = 0; i < 6; i++) drive(1'b1, 6'(6'h3f << i), 18'h3ffff, 10'h2aa, 2'h0, 2'(i));
        // Each maskable source alone at every level and vector table choice
        for (i = 0; i < 18; i++) begin
            for (k = 0; k < 4; k++) drive(1'b1, '0, 18'(18'h1 << i), {5{2'(k)}}, 2'h1, 2'(k));
        end
        repeat (1000) drive_rnd(1'b1);
        repeat (2) drive_rnd(1'b0);
        drive(1'b0, '0, '0, '0, 2'h0, 2'h0);
        drive(1'b1, '0, '0, '0, 2'h0, 2'h0);
        follow = 1'b1;
        repeat (1000) drive_rnd(1'b1);
        drive(1'b1, '0, '0, '0, 2'h0, 2'h0);
        @(posedge mclk_i);
        #2;
        close_out();
    end
endmodule
`default_nettype wire
